//--- design/frac_synth_divider_config.sv
// divider and modulator configuration bank for a fractional-N synthesizer
`default_nettype none
module frac_synth_divider_config
  import frac_synth_pkg::*;
(
  input  wire logic              clk,          // 10 MHz system clock
  input  wire logic              rst_b,        // sync reset, active low
  input  wire logic              soft_rst,     // soft reset strobe from serial host
  input  wire logic              reg_wr,       // register write strobe
  input  wire logic              reg_rd,       // register read strobe
  input  wire logic [4:0]        reg_addr,     // register address
  input  wire logic [DATA_W-1:0] reg_wdata,    // write data
  output logic [DATA_W-1:0]      reg_rdata,    // read data, registered
  input  wire logic              reference_buffer_enable, // analog ref buffer on
  input  wire logic              vco_div_tick, // VCO divider clock enable pulse
  input  wire logic              ref_div_tick, // reference divider clock enable pulse
  input  wire logic              pfd_tick,     // phase detector rate pulse
  output logic [REF_W-1:0]       ref_div_value,   // reference divide value
  output logic                   ref_div_run,     // reference divider active
  output logic [INT_W-1:0]       int_div_value,   // integer divide value
  output logic [FRAC_W-1:0]      frac_div_value,  // applied fraction numerator
  output logic                   freq_change,     // one-cycle change event
  output logic                   seed_load,       // one-cycle seed load strobe
  output logic [FRAC_W-1:0]      seed_value,      // seed loaded at seed_load
  output logic [1:0]             mod_order,       // modulator order code
  output logic                   mod_run,         // modulator core enabled
  output logic                   mod_use_output,  // modulator output feeds divider
  output logic                   mod_clk_tick,    // selected core clock enable
  output logic                   mod_core_delayed,// delayed VCO clock chosen
  output logic                   bist_enable,     // self test on
  output logic [11:0]            bist_length,     // self test reference cycles
  output logic                   aux_serial_data_pin, // aux serial data
  output logic                   aux_serial_clk,  // aux serial bit strobe
  output logic                   aux_serial_frame // aux transfer in progress
);
  logic [REF_W-1:0]  ref_reg, ref_next;
  logic [INT_W-1:0]  int_reg, int_next;
  logic [FRAC_W-1:0] frac_reg, frac_next;
  logic [AUX_W-1:0]  aux_reg, aux_next;
  logic [CFG_W-1:0]  cfg_reg, cfg_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  logic              change_reg, change_next;
  logic              load_reg, load_next;
  logic [FRAC_W-1:0] seed_reg, seed_next;
  logic [FRAC_W-1:0] seed_pick;
  logic              div_write;

  aux_link_if aux_link ();

  // ==========================================================
  // register writes; soft reset restores the defaults of the five writable registers, not read data or seed
  assign div_write = reg_wr && (reg_addr == OFS_INT_DIV || reg_addr == OFS_FRAC_DIV);

  always_comb begin
    ref_next  = ref_reg;
    int_next  = int_reg;
    frac_next = frac_reg;
    aux_next  = aux_reg;
    cfg_next  = cfg_reg;
    if (soft_rst) begin
      ref_next  = REF_DIV_RST;
      int_next  = INT_DIV_RST;
      frac_next = FRAC_DIV_RST;
      aux_next  = AUX_WORD_RST;
      cfg_next  = MOD_CFG_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        OFS_REF_DIV:  ref_next  = reg_wdata[REF_W-1:0];
        OFS_INT_DIV:  int_next  = reg_wdata[INT_W-1:0];
        OFS_FRAC_DIV: frac_next = reg_wdata[FRAC_W-1:0];
        OFS_AUX_WORD: aux_next  = reg_wdata[AUX_W-1:0];
        OFS_MOD_CFG:  cfg_next  = reg_wdata[CFG_W-1:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // seed table
  always_comb begin
    case (cfg_reg[SEED_LSB +: 2])
      SEED_ZERO:  seed_pick = '0;
      SEED_LSB1:  seed_pick = SEED_VAL_LSB;
      SEED_PAT_A: seed_pick = SEED_VAL_A;
      default:    seed_pick = SEED_VAL_B;
    endcase
  end

  // ==========================================================
  // change event, seed load and read port
  // seed is taken from the stored choice, so a pending choice waits for a change
  always_comb begin
    change_next = div_write && !soft_rst;
    load_next   = change_next && cfg_reg[RELOAD_BIT];
    seed_next   = load_next ? seed_pick : seed_reg;
    rdata_next  = rdata_reg;
    if (reg_rd) begin
      case (reg_addr)
        OFS_REF_DIV:  rdata_next = {{(DATA_W-REF_W){1'b0}}, ref_reg};
        OFS_INT_DIV:  rdata_next = {{(DATA_W-INT_W){1'b0}}, int_reg};
        OFS_FRAC_DIV: rdata_next = frac_reg;
        OFS_AUX_WORD: rdata_next = {{(DATA_W-AUX_W){1'b0}}, aux_reg};
        OFS_MOD_CFG:  rdata_next = {{(DATA_W-CFG_W){1'b0}}, cfg_reg};
        default:      rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ref_reg    <= REF_DIV_RST;
      int_reg    <= INT_DIV_RST;
      frac_reg   <= FRAC_DIV_RST;
      aux_reg    <= AUX_WORD_RST;
      cfg_reg    <= MOD_CFG_RST;
      rdata_reg  <= '0;
      change_reg <= 1'b0;
      load_reg   <= 1'b0;
      seed_reg   <= '0;
    end else begin
      ref_reg    <= ref_next;
      int_reg    <= int_next;
      frac_reg   <= frac_next;
      aux_reg    <= aux_next;
      cfg_reg    <= cfg_next;
      rdata_reg  <= rdata_next;
      change_reg <= change_next;
      load_reg   <= load_next;
      seed_reg   <= seed_next;
    end
  end

  // ==========================================================
  // divider and modulator controls
  assign reg_rdata        = rdata_reg;
  assign ref_div_value    = ref_reg;
  assign ref_div_run      = reference_buffer_enable;
  assign int_div_value    = int_reg;
  assign mod_run          = cfg_reg[ENABLE_BIT];
  assign mod_use_output   = !cfg_reg[BYPASS_BIT] && mod_run;
  // fraction only reaches the divider in fractional operation
  assign frac_div_value   = mod_use_output ? frac_reg : '0;
  assign mod_order        = cfg_reg[ORDER_LSB +: 2];
  assign mod_core_delayed = cfg_reg[CORE_BIT];
  // bypass does not stop the core clock: isolation testing needs it running
  assign mod_clk_tick     = mod_run && ((cfg_reg[CORE_BIT] || cfg_reg[FORCE_BIT] ||
                            cfg_reg[SRC_BIT]) ? vco_div_tick : ref_div_tick);
  assign bist_enable      = cfg_reg[BIST_BIT];
  assign bist_length      = BIST_LEN_MIN |
                            (12'(cfg_reg[BLEN_LSB +: 2]) << BIST_STEP_LOG2);
  assign freq_change      = change_reg;
  assign seed_load        = load_reg;
  assign seed_value       = seed_reg;

  // ==========================================================
  // aux serial port launch on each change
  // a change during a running transfer is dropped, never queued
  assign aux_link.start = change_reg && !aux_link.busy;
  assign aux_link.word  = aux_reg;

  aux_serial_port u_aux (
    .clk      (clk),
    .rst_b    (rst_b),
    .pfd_tick (pfd_tick),
    .link     (aux_link.port),
    .sdo      (aux_serial_data_pin),
    .sclk     (aux_serial_clk),
    .frame    (aux_serial_frame)
  );

  // ==========================================================
  // checks
  property p_ref_reset;
    @(posedge clk) disable iff (!rst_b) soft_rst |=> ref_div_value == REF_DIV_RST;
  endproperty
  a_ref_reset: assert property (p_ref_reset) else $error("ref divide not default");

  property p_ref_run;
    @(posedge clk) disable iff (!rst_b) ref_div_run == reference_buffer_enable;
  endproperty
  a_ref_run: assert property (p_ref_run) else $error("ref divider runs unenabled");

  property p_frac_gate;
    @(posedge clk) disable iff (!rst_b) !mod_use_output |-> frac_div_value == '0;
  endproperty
  a_frac_gate: assert property (p_frac_gate) else $error("fraction leaks in integer");

  property p_seed_only_on_change;
    @(posedge clk) disable iff (!rst_b) seed_load |-> freq_change && cfg_reg[RELOAD_BIT];
  endproperty
  a_seed_only_on_change: assert property (p_seed_only_on_change)
    else $error("seed loaded without change");

  property p_reload_follows_write;
    @(posedge clk) disable iff (!rst_b)
      reg_wr && reg_addr == OFS_FRAC_DIV && !soft_rst && cfg_reg[RELOAD_BIT] |=> seed_load;
  endproperty
  a_reload_follows_write: assert property (p_reload_follows_write)
    else $error("fraction write missed seed");

  property p_seed_pattern;
    @(posedge clk) disable iff (!rst_b)
      load_next && cfg_reg[SEED_LSB +: 2] == SEED_PAT_A |=> seed_value == 24'hB29D08;
  endproperty
  a_seed_pattern: assert property (p_seed_pattern) else $error("wrong seed pattern");

  property p_core_off;
    @(posedge clk) disable iff (!rst_b) !mod_run |-> !mod_clk_tick && !mod_use_output;
  endproperty
  a_core_off: assert property (p_core_off) else $error("modulator active while off");

  property p_src_override;
    @(posedge clk) disable iff (!rst_b)
      mod_run && cfg_reg[CORE_BIT] |-> mod_clk_tick == vco_div_tick;
  endproperty
  a_src_override: assert property (p_src_override) else $error("source not overridden");

  property p_aux_start;
    @(posedge clk) disable iff (!rst_b)
      freq_change && !aux_serial_frame |=> aux_serial_frame;
  endproperty
  a_aux_start: assert property (p_aux_start) else $error("aux transfer not started");

  property p_bist_len;
    @(posedge clk) disable iff (!rst_b)
      cfg_reg[BLEN_LSB +: 2] == 2'h3 |-> bist_length == 12'hFFF;
  endproperty
  a_bist_len: assert property (p_bist_len) else $error("bist length wrong");
endmodule
`default_nettype wire

//--- design/frac_synth_pkg.sv
// constants shared by the divider configuration bank and its aux serial port
`default_nettype none
package frac_synth_pkg;
  // register offsets
  localparam logic [4:0] OFS_REF_DIV  = 5'h02;
  localparam logic [4:0] OFS_INT_DIV  = 5'h03;
  localparam logic [4:0] OFS_FRAC_DIV = 5'h04;
  localparam logic [4:0] OFS_AUX_WORD = 5'h05;
  localparam logic [4:0] OFS_MOD_CFG  = 5'h06;
  // field widths
  localparam int REF_W  = 14;
  localparam int INT_W  = 19;
  localparam int FRAC_W = 24;
  localparam int AUX_W  = 16;
  localparam int CFG_W  = 23;
  localparam int DATA_W = 24;
  // reset values
  localparam logic [REF_W-1:0]  REF_DIV_RST  = 14'h0001;
  localparam logic [INT_W-1:0]  INT_DIV_RST  = 19'h000C8;
  localparam logic [FRAC_W-1:0] FRAC_DIV_RST = 24'h000000;
  localparam logic [AUX_W-1:0]  AUX_WORD_RST = 16'h0000;
  localparam logic [CFG_W-1:0]  MOD_CFG_RST  = 23'h000B7A;
  // modulator config field positions
  localparam int SEED_LSB   = 0;
  localparam int ORDER_LSB  = 2;
  localparam int BYPASS_BIT = 7;
  localparam int RELOAD_BIT = 8;
  localparam int SRC_BIT    = 9;
  localparam int CORE_BIT   = 10;
  localparam int ENABLE_BIT = 11;
  localparam int BIST_BIT   = 18;
  localparam int BLEN_LSB   = 19;
  localparam int FORCE_BIT  = 21;
  // seed choices
  localparam logic [1:0]  SEED_ZERO = 2'h0;
  localparam logic [1:0]  SEED_LSB1 = 2'h1;
  localparam logic [1:0]  SEED_PAT_A = 2'h2;
  localparam logic [FRAC_W-1:0] SEED_VAL_LSB = 24'h000001;
  localparam logic [FRAC_W-1:0] SEED_VAL_A   = 24'hB29D08;
  localparam logic [FRAC_W-1:0] SEED_VAL_B   = 24'h50F1CD;
  // modulator orders
  localparam logic [1:0] ORDER_OUT_BAND = 2'h2;
  localparam logic [1:0] ORDER_IN_BAND  = 2'h3;
  // self test length: (code+1)*1024-1 reference cycles
  localparam int          BIST_STEP_LOG2 = 10;
  localparam logic [11:0] BIST_LEN_MIN   = 12'h3FF;
  // aux transfer framing in phase detector ticks
  localparam logic [4:0] AUX_LEAD_TICKS  = 5'h02;
  localparam logic [4:0] AUX_TRAIL_TICKS = 5'h02;
  localparam logic [4:0] AUX_BITS        = 5'h10;
  typedef enum logic [1:0] {AUX_IDLE, AUX_LEAD, AUX_DATA, AUX_TRAIL} aux_state_t;
endpackage
`default_nettype wire

//--- design/aux_link_if.sv
// request/answer carrier between the config bank and the aux serial port
`default_nettype none
interface aux_link_if;
  logic        start;
  logic [15:0] word;
  logic        busy;
  modport bank (output start, output word, input busy);
  modport port (input start, input word, output busy);
endinterface
`default_nettype wire

//--- design/aux_serial_port.sv
// aux serial port: shifts one 16-bit word out at the phase detector rate
`default_nettype none
module aux_serial_port
  import frac_synth_pkg::*;
(
  input  wire logic  clk,        // system clock
  input  wire logic  rst_b,      // sync reset, active low
  input  wire logic  pfd_tick,   // one pulse per phase detector cycle
  aux_link_if.port   link,       // start and word from the bank
  output logic       sdo,        // serial data out
  output logic       sclk,       // one-cycle strobe after each bit
  output logic       frame       // high for the whole transfer
);
  aux_state_t        state_reg, state_next;
  logic [4:0]        cnt_reg, cnt_next;
  logic [AUX_W-1:0]  shift_reg, shift_next;
  logic              sdo_reg, sdo_next;
  logic              drv_reg, drv_next;
  logic              sclk_reg;

  // ==========================================================
  // framing sequencer
  // a start while busy is dropped; the word was captured at start
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    shift_next = shift_reg;
    sdo_next   = sdo_reg;
    drv_next   = 1'b0;
    case (state_reg)
      AUX_IDLE: begin
        if (link.start) begin
          state_next = AUX_LEAD;
          cnt_next   = 5'h00;
          shift_next = link.word;
        end
      end
      AUX_LEAD: begin
        if (pfd_tick) begin
          cnt_next = cnt_reg + 5'h01;
          if (cnt_reg == AUX_LEAD_TICKS - 5'h01) begin
            state_next = AUX_DATA;
            cnt_next   = 5'h00;
            sdo_next   = shift_reg[AUX_W-1];
            shift_next = {shift_reg[AUX_W-2:0], 1'b0};
            drv_next   = 1'b1;
          end
        end
      end
      AUX_DATA: begin
        if (pfd_tick) begin
          cnt_next = cnt_reg + 5'h01;
          if (cnt_reg == AUX_BITS - 5'h01) begin
            state_next = AUX_TRAIL;
            cnt_next   = 5'h00;
            sdo_next   = 1'b0;
          end else begin
            sdo_next   = shift_reg[AUX_W-1];
            shift_next = {shift_reg[AUX_W-2:0], 1'b0};
            drv_next   = 1'b1;
          end
        end
      end
      AUX_TRAIL: begin
        if (pfd_tick) begin
          cnt_next = cnt_reg + 5'h01;
          if (cnt_reg == AUX_TRAIL_TICKS - 5'h01) begin
            state_next = AUX_IDLE;
          end
        end
      end
      default: state_next = AUX_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_reg <= AUX_IDLE;
      cnt_reg   <= 5'h00;
      shift_reg <= AUX_WORD_RST;
      sdo_reg   <= 1'b0;
      drv_reg   <= 1'b0;
      sclk_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      shift_reg <= shift_next;
      sdo_reg   <= sdo_next;
      drv_reg   <= drv_next;
      sclk_reg  <= drv_reg;
    end
  end

  assign link.busy = (state_reg != AUX_IDLE);
  assign sdo       = sdo_reg;
  assign sclk      = sclk_reg;
  assign frame     = (state_reg != AUX_IDLE);
endmodule
`default_nettype wire

//--- dv/serial_host_model.sv
// serial host model: issues register writes, reads and soft resets
`default_nettype none
module serial_host_model
  import frac_synth_pkg::*;
#(
  parameter int PFD_MHZ = 10               // phase detector rate the host plans for
) (
  input  wire logic              clk,         // system clock
  output logic                   soft_rst,    // soft reset strobe
  output logic                   reg_wr,      // write strobe
  output logic                   reg_rd,      // read strobe
  output logic [4:0]             reg_addr,    // register address
  output logic [DATA_W-1:0]      reg_wdata,   // write data
  input  wire logic [DATA_W-1:0] reg_rdata,   // read data
  input  wire logic              freq_change, // change event pulse
  input  wire logic              seed_load,   // seed load pulse
  input  wire logic [FRAC_W-1:0] seed_value   // seed loaded
);
  timeunit 1ns;
  timeprecision 1ns;
  // =====================================================
  // idle levels
  initial begin
    soft_rst  = 1'b0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 5'h00;
    reg_wdata = 24'h000000;
  end
  // =====================================================
  // one write; address and data are inverted on release so stale values never look valid
  task automatic wr(input logic [4:0] a, input logic [DATA_W-1:0] d, output logic fc,
                    output logic sl, output logic [FRAC_W-1:0] sv);
    logic [DATA_W-1:0] v;
    v = d;
    if (a == OFS_MOD_CFG && v[3:2] == ORDER_IN_BAND) begin
      v[17:16] = (PFD_MHZ >= 50) ? 2'h3 : 2'h0;
    end
    if (a == OFS_INT_DIV && (v < 24'h000014 || v > 24'h07FFFC)) begin
      v = {5'h00, INT_DIV_RST}; // out of range is never sent
    end
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~v;
    #1;
    fc = freq_change;
    sl = seed_load;
    sv = seed_value;
  endtask
  // one read; data is taken after the answering edge
  task automatic rd(input logic [4:0] a, output logic [DATA_W-1:0] q);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    #1;
    q = reg_rdata;
  endtask
  // soft reset strobe
  task automatic srst();
    @(posedge clk);
    soft_rst <= 1'b1;
    @(posedge clk);
    soft_rst <= 1'b0;
    #1;
  endtask
endmodule
`default_nettype wire

//--- dv/tb.sv
// testbench for the divider configuration bank
`default_nettype none
module tb
  import frac_synth_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_b, soft_rst, reg_wr, reg_rd, reference_buffer_enable;
  logic vco_div_tick, ref_div_tick, pfd_tick, freq_change, seed_load;
  logic [4:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, q;
  logic [REF_W-1:0] ref_div_value;
  logic [INT_W-1:0] int_div_value;
  logic [FRAC_W-1:0] frac_div_value, seed_value, sv;
  logic [1:0] mod_order;
  logic ref_div_run, mod_run, mod_use_output, mod_clk_tick, mod_core_delayed, bist_enable;
  logic [11:0] bist_length;
  logic aux_serial_data_pin, aux_serial_clk, aux_serial_frame, fc, sl;
  logic [3:0] tick_cnt;
  logic [15:0] bits;
  int n_errors, tests_run, nb, nf;
  logic [FRAC_W-1:0] seeds [4];
  // =====================================================
  // clock and slow clock enables; pfd every 4 cycles
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    tick_cnt = 4'h0; vco_div_tick = 1'b0; ref_div_tick = 1'b0; pfd_tick = 1'b0;
  end
  always @(posedge clk) begin
    tick_cnt     <= tick_cnt + 4'h1;
    pfd_tick     <= (tick_cnt[1:0] == 2'h3);
    vco_div_tick <= tick_cnt[0];
    ref_div_tick <= (tick_cnt[2:0] == 3'h5);
  end
  // =====================================================
  serial_host_model #(.PFD_MHZ(10)) serial_host_model_i (.clk(clk), .soft_rst(soft_rst),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .freq_change(freq_change), .seed_load(seed_load),
    .seed_value(seed_value));
  frac_synth_divider_config frac_synth_divider_config_i (.clk(clk), .rst_b(rst_b),
    .soft_rst(soft_rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reference_buffer_enable(reference_buffer_enable), .vco_div_tick(vco_div_tick),
    .ref_div_tick(ref_div_tick), .pfd_tick(pfd_tick), .ref_div_value(ref_div_value),
    .ref_div_run(ref_div_run), .int_div_value(int_div_value),
    .frac_div_value(frac_div_value), .freq_change(freq_change), .seed_load(seed_load),
    .seed_value(seed_value), .mod_order(mod_order), .mod_run(mod_run),
    .mod_use_output(mod_use_output), .mod_clk_tick(mod_clk_tick),
    .mod_core_delayed(mod_core_delayed), .bist_enable(bist_enable),
    .bist_length(bist_length), .aux_serial_data_pin(aux_serial_data_pin),
    .aux_serial_clk(aux_serial_clk), .aux_serial_frame(aux_serial_frame));
  // =====================================================
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("errors %0d, comparisons %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // =====================================================
  // defaults after reset, unmapped reads give zero
  task automatic t_defaults();
    serial_host_model_i.rd(OFS_REF_DIV, q); chk(q, 24'h000001);
    serial_host_model_i.rd(OFS_INT_DIV, q); chk(q, 24'h0000C8);
    serial_host_model_i.rd(OFS_FRAC_DIV, q); chk(q, 24'h000000);
    serial_host_model_i.rd(OFS_AUX_WORD, q); chk(q, 24'h000000);
    serial_host_model_i.rd(OFS_MOD_CFG, q); chk(q, 24'h000B7A);
    serial_host_model_i.rd(5'h1F, q); chk(q, 24'h000000);
    chk(mod_run, 1'b1);
    chk(mod_order, ORDER_OUT_BAND);
  endtask
  // reference divide limits, width and buffer gating
  task automatic t_ref();
    serial_host_model_i.wr(OFS_REF_DIV, 24'hFFFFFF, fc, sl, sv);
    chk(ref_div_value, 14'h3FFF);
    serial_host_model_i.rd(OFS_REF_DIV, q); chk(q, 24'h003FFF);
    serial_host_model_i.wr(OFS_REF_DIV, 24'h000000, fc, sl, sv);
    chk(ref_div_value, 14'h0000);
    @(posedge clk) reference_buffer_enable <= 1'b0;
    #1 chk(ref_div_run, 1'b0);
    @(posedge clk) reference_buffer_enable <= 1'b1;
    #1 chk(ref_div_run, 1'b1);
  endtask
  // every seed choice, loaded only on a divide write with reload set
  task automatic t_seed();
    for (int s = 0; s < 4; s++) begin
      serial_host_model_i.wr(OFS_MOD_CFG, {1'b0, MOD_CFG_RST[22:2], s[1:0]}, fc, sl, sv);
      chk({fc, sl}, 2'h0);
      serial_host_model_i.wr(OFS_FRAC_DIV, 24'(24'h123450 + s), fc, sl, sv);
      chk({fc, sl}, 2'h3);
      chk(sv, seeds[s]);
      chk(frac_div_value, 24'(24'h123450 + s));
    end
    serial_host_model_i.wr(OFS_MOD_CFG, 24'h000A7A, fc, sl, sv);
    serial_host_model_i.wr(OFS_INT_DIV, 24'h07FFFC, fc, sl, sv);
    chk({fc, sl}, 2'h2);
    chk(int_div_value, 19'h7FFFC);
  endtask
  // bypass, core enable, order, self test, clock source
  task automatic t_mode();
    serial_host_model_i.wr(OFS_MOD_CFG, 24'h000BFA, fc, sl, sv);
    chk({mod_run, mod_use_output}, 2'h2);
    chk(frac_div_value, 24'h000000);
    // bypass leaves the core clocked from the vco divider
    repeat (2) begin
      @(posedge clk) #1 chk(mod_clk_tick, vco_div_tick);
    end
    serial_host_model_i.wr(OFS_MOD_CFG, 24'h00037A, fc, sl, sv);
    chk({mod_run, mod_use_output}, 2'h0);
    repeat (4) begin
      @(posedge clk) #1 chk(mod_clk_tick, 1'b0);
    end
    serial_host_model_i.wr(OFS_MOD_CFG, 24'h000B7E, fc, sl, sv);
    chk(mod_order, ORDER_IN_BAND);
    for (int c = 0; c < 4; c++) begin
      serial_host_model_i.wr(OFS_MOD_CFG, 24'(24'h040B7A | (c << 19)), fc, sl, sv);
      chk({bist_enable, bist_length}, {1'b1, 12'(((c + 1) << 10) - 1)});
    end
    for (int i = 0; i < 8; i++) begin
      serial_host_model_i.wr(OFS_MOD_CFG, 24'h00097A | (i[0] << 9) | (i[1] << 10)
                             | (i[2] << 21), fc, sl, sv);
      chk(mod_core_delayed, i[1]);
      repeat (6) begin
        @(posedge clk) #1 chk(mod_clk_tick, (i != 0) ? vco_div_tick : ref_div_tick);
      end
    end
  endtask
  // aux word goes out msb first; a change during a running frame starts no second frame
  task automatic t_aux();
    serial_host_model_i.wr(OFS_AUX_WORD, 24'hFFA5C3, fc, sl, sv);
    serial_host_model_i.rd(OFS_AUX_WORD, q); chk(q, 24'h00A5C3);
    serial_host_model_i.wr(OFS_INT_DIV, 24'h000200, fc, sl, sv);
    bits = 16'h0000; nb = 0; nf = 0;
    // a second change while the frame runs must not start another transfer
    fork
      serial_host_model_i.wr(OFS_INT_DIV, 24'h000201, fc, sl, sv);
    join_none
    for (int k = 0; k < 300 && !(nf > 0 && !aux_serial_frame); k++) begin
      @(posedge clk) #1;
      if (aux_serial_frame) nf++;
      if (aux_serial_clk) begin
        bits = {bits[14:0], aux_serial_data_pin};
        nb++;
      end
    end
    chk(bits, 16'hA5C3);
    chk(24'(nb), 24'h000010);
    chk(nf >= 76 && nf <= 84, 1'b1); // frame spans 20 ticks of 4 cycles
    nb = 0;
    repeat (100) begin
      @(posedge clk) #1 nb += aux_serial_frame;
    end
    chk(24'(nb), 24'h000000); // refused change gave no second frame
  endtask
  // soft reset restores defaults
  task automatic t_soft();
    serial_host_model_i.wr(OFS_REF_DIV, 24'h000055, fc, sl, sv);
    serial_host_model_i.srst();
    chk(ref_div_value, 14'h0001);
    serial_host_model_i.rd(OFS_MOD_CFG, q); chk(q, 24'h000B7A);
  endtask
  // =====================================================
  // watchdog: whole run needs well under 3000 cycles
  initial begin
    #2000000;
    n_errors++;
    end_of_test();
  end
  initial begin
    n_errors = 0; tests_run = 0;
    seeds = '{24'h000000, SEED_VAL_LSB, SEED_VAL_A, SEED_VAL_B};
    rst_b = 1'b0;
    reference_buffer_enable = 1'b1;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    t_defaults();
    t_ref();
    t_seed();
    t_mode();
    t_aux();
    t_soft();
    end_of_test();
  end
endmodule
`default_nettype wire
